// >>> rtl/shsc_ctrl.sv
// Standby controller: halt and stop entry, wake and clock gating.
`timescale 1ns/1ps
`default_nettype none
module shsc_ctrl #(
	parameter int unsigned N_IRQ = shsc_pkg::SHSC_NUM_IRQ
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_halt_exec,
	input  wire logic             i_stop_exec,
	input  wire logic             i_irq_accept_enabled,
	input  wire logic             i_cpu_on_slow_clk,
	input  wire logic [N_IRQ-1:0] i_irq_req,
	input  wire logic [N_IRQ-1:0] i_irq_mask,
	input  wire logic             i_crc_done,
	input  wire logic             i_hs_sys_osc_run,
	input  wire logic             i_hs_int_osc_run,
	input  wire logic             i_pll_run_bit,
	input  wire logic             i_ls_int_osc_run,
	input  wire logic             i_sub_osc_run,
	input  wire logic             i_watchdog_enable_option,
	input  wire logic             i_watchdog_standby_run_option,
	output logic                  o_cpu_clk_en,
	output logic                  o_halted,
	output logic                  o_stopped,
	output logic                  o_wake_vector,
	output logic                  o_wake_resume,
	output logic                  o_hs_sys_osc_en,
	output logic                  o_hs_int_osc_en,
	output logic                  o_pll_en,
	output logic                  o_ls_int_osc_en,
	output logic                  o_sub_osc_en,
	output logic                  o_wdt_osc_en,
	output logic                  o_wdt_cnt_clr
);
	import shsc_pkg::*;

	initial begin
		if (N_IRQ != SHSC_NUM_IRQ)
			$error("N_IRQ must match the source map width");
	end

	shsc_state_t state_q;
	shsc_state_t state_d;
	logic        accept_q;
	logic        wdt_stopped_q;
	logic        hs_sys_save_q;
	logic        hs_int_save_q;
	logic        wake;
	logic        go_run;

	// Pending unmasked requests, filtered by mode and clock selection.
	function automatic logic wake_of(input logic [N_IRQ-1:0] req, input logic [N_IRQ-1:0] msk,
		input logic [N_IRQ-1:0] permit);
		wake_of = |(req & ~msk & permit);
	endfunction

	always_comb begin
		logic [N_IRQ-1:0] permit;
		permit = SHSC_MAIN_MASK;
		if (state_q == SHSC_STOP)
			permit = SHSC_STOP_MASK;
		else if (i_cpu_on_slow_clk)
			permit = SHSC_SLOW_MASK;
		wake = wake_of(i_irq_req, i_irq_mask, permit);
	end

	assign go_run = (state_q == SHSC_HALT && (wake || i_crc_done))
		|| (state_q == SHSC_STOP && wake);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SHSC_RUN: begin
				// An entry with a pending request is swallowed: the CPU keeps its clock.
				if (i_stop_exec && !wake)
					state_d = SHSC_STOP;
				else if (i_halt_exec && !(wake || i_crc_done))
					state_d = SHSC_HALT;
			end
			SHSC_HALT: begin
				if (go_run)
					state_d = SHSC_RUN;
			end
			SHSC_STOP: begin
				if (go_run)
					state_d = SHSC_RUN;
			end
			default: state_d = SHSC_RUN;
		endcase
	end

	// Reset returns to run from any standby state.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			state_q <= SHSC_RUN;
		else
			state_q <= state_d;
	end

	// The gate only changes on a clock edge, so no partial pulse escapes.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_cpu_clk_en <= 1'b1;
		else
			o_cpu_clk_en <= (state_d == SHSC_RUN);
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_halted  <= 1'b0;
			o_stopped <= 1'b0;
		end else begin
			o_halted  <= (state_d == SHSC_HALT);
			o_stopped <= (state_d == SHSC_STOP);
		end
	end

	// Acceptance is latched at each entry attempt in run; every exit uses the latched value.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			accept_q <= 1'b0;
		else if (state_q == SHSC_RUN && (i_halt_exec || i_stop_exec))
			accept_q <= i_irq_accept_enabled;
	end

	// One-cycle exit indication: vector or continue after the instruction.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wake_vector <= 1'b0;
			o_wake_resume <= 1'b0;
		end else begin
			o_wake_vector <= go_run && accept_q && wake;
			o_wake_resume <= go_run && !(accept_q && wake);
		end
	end

	// Main oscillator states captured at stop entry for later restore.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hs_sys_save_q <= 1'b0;
			hs_int_save_q <= 1'b1;
		end else if (state_q == SHSC_RUN && state_d == SHSC_STOP) begin
			hs_sys_save_q <= i_hs_sys_osc_run;
			hs_int_save_q <= i_hs_int_osc_run;
		end
	end

	// Halt passes all requests through; stop forces the main sources and PLL off.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_hs_sys_osc_en <= 1'b0;
			o_hs_int_osc_en <= 1'b1;
			o_pll_en        <= 1'b0;
			o_ls_int_osc_en <= 1'b0;
			o_sub_osc_en    <= 1'b0;
		end else if (state_d == SHSC_STOP) begin
			o_hs_sys_osc_en <= 1'b0;
			o_hs_int_osc_en <= 1'b0;
			o_pll_en        <= 1'b0;
			o_ls_int_osc_en <= i_ls_int_osc_run;
			o_sub_osc_en    <= i_sub_osc_run;
		end else if (state_q == SHSC_STOP) begin
			o_hs_sys_osc_en <= hs_sys_save_q;
			o_hs_int_osc_en <= hs_int_save_q;
			o_pll_en        <= 1'b0;
			o_ls_int_osc_en <= i_ls_int_osc_run;
			o_sub_osc_en    <= i_sub_osc_run;
		end else begin
			o_hs_sys_osc_en <= i_hs_sys_osc_run;
			o_hs_int_osc_en <= i_hs_int_osc_run;
			o_pll_en        <= i_pll_run_bit;
			o_ls_int_osc_en <= i_ls_int_osc_run;
			o_sub_osc_en    <= i_sub_osc_run;
		end
	end

	// Watchdog oscillator stops in standby unless its standby-run option is set.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wdt_osc_en  <= 1'b0;
			wdt_stopped_q <= 1'b0;
			o_wdt_cnt_clr <= 1'b0;
		end else begin
			o_wdt_cnt_clr <= 1'b0;
			if (state_d != SHSC_RUN && i_watchdog_enable_option && !i_watchdog_standby_run_option) begin
				o_wdt_osc_en  <= 1'b0;
				wdt_stopped_q <= 1'b1;
			end else begin
				o_wdt_osc_en <= i_watchdog_enable_option;
				if (state_d == SHSC_RUN && wdt_stopped_q) begin
					o_wdt_cnt_clr <= 1'b1;
					wdt_stopped_q <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/shsc_pkg.sv
// Constants for the standby halt/stop controller.
// Function
// - Halt gates CPU clock, oscillators untouched.
// - All clock sources keep state through halt.
// - Unmasked pending request ends halt.
// - Exit vectors if accepting, else continues.
// - Flash CRC completion also ends halt.
// - Request pending at halt entry exits immediately.
// - Any reset terminates halt.
// - Watchdog oscillator run/stop in halt per option.
// - Slow CPU clock limits halt wake sources.
// - Stop gates CPU clock and main oscillators.
// - Unmasked pending request ends stop.
// - Exit from stop vectors or continues.
// - Main oscillators restored after stop; slow unchanged.
// - PLL off before stop, stays off.
// - Watchdog oscillator run/stop in stop per option.
// - Request pending at stop entry exits immediately.
// - Any reset terminates stop.
package shsc_pkg;
	localparam int unsigned SHSC_NUM_IRQ = 16;
	// Interrupt source positions on the request and mask vectors.
	localparam int unsigned SHSC_IRQ_TAU  = 0;
	localparam int unsigned SHSC_IRQ_RTC  = 1;
	localparam int unsigned SHSC_IRQ_CMON = 2;
	localparam int unsigned SHSC_IRQ_TRJ  = 3;
	localparam int unsigned SHSC_IRQ_TRD  = 4;
	localparam int unsigned SHSC_IRQ_ADC  = 5;
	localparam int unsigned SHSC_IRQ_CMP  = 6;
	localparam int unsigned SHSC_IRQ_SAU  = 7;
	localparam int unsigned SHSC_IRQ_IIC  = 8;
	localparam int unsigned SHSC_IRQ_LIN  = 9;
	localparam int unsigned SHSC_IRQ_CAN  = 10;
	localparam int unsigned SHSC_IRQ_DTC  = 11;
	localparam int unsigned SHSC_IRQ_LVD  = 12;
	localparam int unsigned SHSC_IRQ_EXT  = 13;
	localparam int unsigned SHSC_IRQ_KEY  = 14;
	localparam int unsigned SHSC_IRQ_WDT  = 15;
	// Sources permitted when the CPU runs from a slow clock.
	localparam logic [15:0] SHSC_SLOW_MASK = 16'hf89b;
	// Sources permitted when the CPU runs from a main clock.
	localparam logic [15:0] SHSC_MAIN_MASK = 16'hffff;
	// Sources permitted to end stop.
	localparam logic [15:0] SHSC_STOP_MASK = 16'hf14a;
	typedef enum logic [2:0] {
		SHSC_RUN  = 3'h1,
		SHSC_HALT = 3'h2,
		SHSC_STOP = 3'h4
	} shsc_state_t;
endpackage

// >>> tb/shsc_ctrl_props.sv
// Assertion checker for the standby controller, bound to its ports.
`timescale 1ns/1ps
`default_nettype none
module shsc_ctrl_props
	import shsc_pkg::*;
#(
	parameter int unsigned N_IRQ = 16
) (
	input wire logic i_clk, i_reset_n, i_halt_exec, i_stop_exec, i_cpu_on_slow_clk, i_crc_done,
	input wire logic i_watchdog_enable_option, i_watchdog_standby_run_option,
	input wire logic [N_IRQ-1:0] i_irq_req, i_irq_mask,
	input wire logic o_cpu_clk_en, o_halted, o_stopped, o_wake_vector, o_wake_resume,
	input wire logic o_hs_sys_osc_en, o_hs_int_osc_en, o_pll_en, o_wdt_osc_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire logic [15:0] perm = i_cpu_on_slow_clk ? SHSC_SLOW_MASK : SHSC_MAIN_MASK;
	wire logic hw = |(i_irq_req & ~i_irq_mask & perm);
	wire logic sw = |(i_irq_req & ~i_irq_mask & SHSC_STOP_MASK);
	wire logic run = !o_halted && !o_stopped;
	chk_halt_entry: assert property (
		run && i_halt_exec && !i_stop_exec && !hw && !i_crc_done |=> o_halted && !o_cpu_clk_en)
		else $error("halt entry missed");
	chk_halt_osc_kept: assert property (
		o_halted |-> $stable({o_hs_sys_osc_en, o_hs_int_osc_en, o_pll_en}))
		else $error("clock source changed in halt");
	chk_halt_wake: assert property (
		o_halted && (hw || i_crc_done) |=> !o_halted && o_cpu_clk_en) else $error("halt not released");
	chk_slow_no_wake: assert property (
		o_halted && !hw && !i_crc_done |=> o_halted) else $error("halt left without cause");
	chk_pending_refuse: assert property (
		run && (i_halt_exec && hw || i_stop_exec && sw) |=> run) else $error("entry not refused");
	chk_stop_osc_off: assert property (
		o_stopped |-> !(o_hs_sys_osc_en || o_hs_int_osc_en || o_pll_en || o_cpu_clk_en))
		else $error("clock running in stop");
	chk_stop_wake: assert property (
		o_stopped && sw |=> !o_stopped && o_cpu_clk_en) else $error("stop not released");
	chk_exit_one_pulse: assert property (
		$fell(o_halted) || $fell(o_stopped) |-> o_wake_vector ^ o_wake_resume)
		else $error("exit pulse wrong");
	chk_wdt_osc_stops: assert property (
		(o_halted || o_stopped) && $past(o_halted || o_stopped) && i_watchdog_enable_option
		&& !i_watchdog_standby_run_option |-> !o_wdt_osc_en) else $error("watchdog osc running");
	chk_pll_after_stop: assert property (
		$fell(o_stopped) |-> !o_pll_en) else $error("pll on after stop");
endmodule
bind shsc_ctrl shsc_ctrl_props #(.N_IRQ(N_IRQ)) shsc_ctrl_props_i (.*);
`default_nettype wire

// >>> tb/shsc_cpu_model.sv
// Partner model: CPU core issuing standby instructions, plus request flags.
`timescale 1ns/1ps
`default_nettype none
module shsc_cpu_model (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_do_halt,
	input  wire logic        i_do_stop,
	input  wire logic        i_slow,
	input  wire logic        i_pll,
	input  wire logic        i_ack,
	input  wire logic [15:0] i_raise,
	output logic             o_halt_exec,
	output logic             o_stop_exec,
	output logic [15:0]      o_irq_req
);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_halt_exec <= 1'b0;
			o_stop_exec <= 1'b0;
			o_irq_req   <= 16'h0;
		end else begin
			o_halt_exec <= i_do_halt;
			o_stop_exec <= i_do_stop && !i_slow && !i_pll;
			o_irq_req   <= i_ack ? 16'h0 : (o_irq_req | i_raise);
		end
	end
endmodule
`default_nettype wire

// >>> tb/test_standby_halt_stop_control.sv
// Self-checking bench for the standby controller.
`timescale 1ns/1ps
`default_nettype none
module test_standby_halt_stop_control;
	logic i_clk = 0, i_reset_n = 0, i_halt_exec, i_stop_exec, i_irq_accept_enabled = 0, i_crc_done = 0;
	logic i_cpu_on_slow_clk = 0, i_hs_sys_osc_run = 0, i_hs_int_osc_run = 1, i_pll_run_bit = 0;
	logic i_ls_int_osc_run = 1, i_sub_osc_run = 1, i_watchdog_enable_option = 1;
	logic i_watchdog_standby_run_option = 1, dh = 0, ds = 0, sv = 0, sr = 0, cc = 0;
	logic [15:0] i_irq_req, i_irq_mask = 16'h0080, raise = 16'h0;
	logic o_cpu_clk_en, o_halted, o_stopped, o_wake_vector, o_wake_resume, o_hs_sys_osc_en;
	logic o_hs_int_osc_en, o_pll_en, o_ls_int_osc_en, o_sub_osc_en, o_wdt_osc_en, o_wdt_cnt_clr;
	int fails = 0, n_compared = 0, cyc = 0;
	// Row bits: stop, slow clock, accept, wake expected, source index.
	logic [7:0] rows [8] = '{8'h30, 8'h1a, 8'h65, 8'h7e, 8'h27, 8'hb1, 8'ha0, 8'h9d};
	logic [7:0] r;
	shsc_ctrl shsc_ctrl_i (.*);
	shsc_cpu_model shsc_cpu_model_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_do_halt(dh),
		.i_do_stop(ds), .i_slow(i_cpu_on_slow_clk), .i_pll(i_pll_run_bit), .i_ack(o_wake_vector),
		.i_raise(raise), .o_halt_exec(i_halt_exec), .o_stop_exec(i_stop_exec), .o_irq_req(i_irq_req));
	always #12.5 i_clk = ~i_clk;
	// Wake pulses last one cycle, so they are latched for the later check.
	always @(posedge i_clk) begin
		sv <= sv | o_wake_vector;
		sr <= sr | o_wake_resume;
		cc <= cc | o_wdt_cnt_clr;
		cyc++;
		if (cyc == 3000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic chk(string n, logic e, logic g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic enter(logic s);
		@(posedge i_clk);
		dh <= !s;
		ds <= s;
		@(posedge i_clk);
		dh <= 0;
		ds <= 0;
		repeat (3) @(posedge i_clk);
		#1;
	endtask
	task automatic pulse_raise(logic [15:0] v);
		@(posedge i_clk) raise <= v;
		@(posedge i_clk) raise <= 16'h0;
		repeat (3) @(posedge i_clk);
		#1;
	endtask
	task automatic rst();
		@(posedge i_clk) i_reset_n <= 0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1;
		@(posedge i_clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_reset_n <= 1;
		foreach (rows[k]) begin
			r = rows[k];
			@(posedge i_clk);
			{i_cpu_on_slow_clk, i_irq_accept_enabled, i_hs_sys_osc_run} <= {r[6], r[5], r[0]};
			enter(r[7]);
			chk("standby", 1, r[7] ? o_stopped : o_halted);
			chk("cpu_clk", 0, o_cpu_clk_en);
			chk("hs_int", !r[7], o_hs_int_osc_en);
			chk("hs_sys", r[0] & !r[7], o_hs_sys_osc_en);
			chk("ls_int", 1, o_ls_int_osc_en);
			chk("sub_osc", 1, o_sub_osc_en);
			chk("pll_off", 0, o_pll_en);
			chk("wdt_run", 1, o_wdt_osc_en);
			sv = 0;
			sr = 0;
			pulse_raise(16'h1 << r[3:0]);
			chk("woke", r[4], o_cpu_clk_en);
			chk("vector", r[4] & r[5], sv);
			chk("resume", r[4] & !r[5], sr);
			chk("hs_back", r[0] & (r[4] | !r[7]), o_hs_sys_osc_en);
			rst();
			chk("reset_ends", 1, o_cpu_clk_en & !o_halted & !o_stopped);
		end
		for (int s = 0; s < 2; s++) begin
			pulse_raise(16'h0002);
			enter(s[0]);
			chk("refused", 0, o_halted | o_stopped);
			rst();
		end
		@(posedge i_clk) i_watchdog_standby_run_option <= 0;
		i_irq_mask <= 16'h0;
		enter(0);
		chk("wdt_off", 0, o_wdt_osc_en);
		sr = 0;
		cc = 0;
		@(posedge i_clk) i_crc_done <= 1;
		@(posedge i_clk) i_crc_done <= 0;
		repeat (3) @(posedge i_clk);
		#1;
		chk("crc_exit", 0, o_halted);
		chk("crc_resume", 1, sr);
		chk("wdt_again", 1, o_wdt_osc_en);
		chk("wdt_clr", 1, cc);
		print_verdict();
	end
endmodule
`default_nettype wire
